// ### rtl/isp_engine.sv
// Serial programming engine: decodes four-byte instructions and drives the memories
// Assumes the programmer holds rst_pin_n low for the session and paces sck slowly
// Function
// - MOSI bits are taken on each rising serial clock edge.
// - MISO bits change on each falling serial clock edge.
// - While byte three shifts in, byte two is echoed on MISO.
// - Flash buffer loads one byte per instruction, low byte first.
// - Page write commits the buffer to the page from the upper address bits.
// - EEPROM byte write overwrites its location; 3.6 ms wait applies.
// - EEPROM page write changes only the bytes loaded into its buffer.
// - Instructions are four bytes; enable and erase codes are fixed.
// - Busy poll returns the pending flag in bit zero of byte four.
// - Load codes fill flash buffer, EEPROM buffer or extended address.
// - Flash and EEPROM reads return addressed data in byte four while no commit is pending.
// - Lock, fuse, signature and calibration reads return in byte four.
// - Write codes commit flash page, EEPROM byte or EEPROM page.
// - Lock and fuse writes take byte four; a zero programs a bit.
// - Flash addresses are word addresses anywhere inside the page.
// - Reset pin high ends programming mode and normal operation resumes.
// - Any memory location can be read back for verification.
// - Nothing but programming enable is obeyed after reset goes low.
// - Chip erase fills all flash and EEPROM with 0xFF.
`timescale 1ns/100ps
module isp_engine import isp_pkg::*; #(
	parameter int FL_AW = FLASH_ADDR_W,
	parameter int EE_AW = EE_ADDR_W,
	parameter int unsigned FLASH_WAIT = FLASH_PAGE_WAIT_CYC,
	parameter int unsigned EE_WAIT = EEPROM_WRITE_WAIT_CYC,
	parameter int unsigned ERASE_WAIT = CHIP_ERASE_WAIT_CYC,
	parameter int unsigned FUSE_WAIT = FUSE_WRITE_WAIT_CYC,
	parameter logic [7:0] SIG0 = 8'h5A, // Arbitrary value
	parameter logic [7:0] SIG1 = 8'hA5, // Arbitrary value
	parameter logic [7:0] SIG2 = 8'h01 // Arbitrary value
) (
	// System
	input wire logic clk_sys,
	input wire logic reset_n,
	// Programming pins
	input wire logic rst_pin_n,
	input wire logic sck,
	input wire logic mosi,
	output logic miso,
	// Status
	output logic prog_enabled,
	output logic op_pending
);
	localparam int PG_W = FLASH_PAGE_W;
	localparam int PN_W = FL_AW - PG_W;
	localparam int EP_W = EE_PAGE_W;

	isp_byte_if bus ();

	logic [FL_AW-1:0] fa;
	logic fwe;
	logic [15:0] fwd, frd;
	logic [PG_W-1:0] ba;
	logic bwe;
	logic [15:0] bwd, brd;
	logic [EE_AW-1:0] ea;
	logic ewe;
	logic [7:0] ewd, erd;

	isp_mem #(.W(16), .AW(FL_AW)) u_flash (
		.clk_sys(clk_sys),
		.we(fwe),
		.addr(fa),
		.wdata(fwd),
		.rdata(frd)
	);

	isp_mem #(.W(16), .AW(PG_W)) u_pbuf (
		.clk_sys(clk_sys),
		.we(bwe),
		.addr(ba),
		.wdata(bwd),
		.rdata(brd)
	);

	isp_mem #(.W(8), .AW(EE_AW)) u_eeprom (
		.clk_sys(clk_sys),
		.we(ewe),
		.addr(ea),
		.wdata(ewd),
		.rdata(erd)
	);

	isp_link u_link (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.sck(sck),
		.mosi(mosi),
		.miso(miso),
		.bus(bus.link)
	);

	// Reset pin synchroniser
	logic rp_s1_r, rp_s2_r, in_mode;

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			rp_s1_r <= 1'b1;
			rp_s2_r <= 1'b1;
		end else begin
			rp_s1_r <= rst_pin_n;
			rp_s2_r <= rp_s1_r;
		end
	end

	assign in_mode = !rp_s2_r;
	assign bus.active = in_mode;

	// Instruction state
	logic [7:0] b1_r, b1_nxt, b2_r, b2_nxt, b3_r, b3_nxt, ext_r, ext_nxt;
	logic [7:0] lock_r, lock_nxt, fl_r, fl_nxt, fh_r, fh_nxt, fe_r, fe_nxt;
	logic [7:0] tx_r, tx_nxt, lo_r, lo_nxt;
	logic [PG_W-1:0] loa_r, loa_nxt;
	logic lov_r, lov_nxt;
	logic [7:0] eb_r [2**EP_W];
	logic [7:0] eb_nxt [2**EP_W];
	logic [2**EP_W-1:0] em_r, em_nxt;
	logic [EE_AW-EP_W-1:0] epg_r, epg_nxt;
	logic [PN_W-1:0] pg_r, pg_nxt;
	logic [31:0] cnt_r, cnt_nxt;
	logic en_r, en_nxt, pend_r, pend_nxt;
	isp_state_e st_r, st_nxt;
	isp_rsel_e rs_r, rs_nxt;
	logic [7:0] rd;
	logic [23:0] wa, ra;
	logic idle, go;

	always_comb begin
		b1_nxt = b1_r;
		b2_nxt = b2_r;
		b3_nxt = b3_r;
		ext_nxt = ext_r;
		lock_nxt = lock_r;
		fl_nxt = fl_r;
		fh_nxt = fh_r;
		fe_nxt = fe_r;
		tx_nxt = tx_r;
		lo_nxt = lo_r;
		loa_nxt = loa_r;
		lov_nxt = lov_r;
		eb_nxt = eb_r;
		em_nxt = em_r;
		epg_nxt = epg_r;
		pg_nxt = pg_r;
		cnt_nxt = cnt_r;
		en_nxt = en_r;
		st_nxt = st_r;
		rs_nxt = RS_NONE;
		fa = '0;
		fwe = 1'b0;
		fwd = 16'h0000;
		ba = '0;
		bwe = 1'b0;
		bwd = 16'h0000;
		ea = '0;
		ewe = 1'b0;
		ewd = 8'h00;
		rd = bus.rx_byte;
		wa = {ext_r, b2_r, b3_r};
		ra = {ext_r, b2_r, rd};
		idle = (st_r == ST_IDLE);
		go = en_r && idle;
		// Read data lands one cycle after the address
		case (rs_r)
			RS_FHI: tx_nxt = frd[15:8];
			RS_FLO: tx_nxt = frd[7:0];
			RS_EE: tx_nxt = erd;
			default: ;
		endcase
		// Commit sequencer
		case (st_r)
			ST_IDLE: ;
			ST_FLASH: begin
				ba = cnt_r[PG_W-1:0];
				if (cnt_r != 32'd0) begin
					fwe = 1'b1;
					fa = {pg_r, PG_W'(cnt_r - 32'd1)};
					fwd = brd;
				end
				if (cnt_r == 32'(2**PG_W)) begin
					st_nxt = ST_WAIT;
					cnt_nxt = 32'(FLASH_WAIT);
				end else begin
					cnt_nxt = cnt_r + 32'd1;
				end
			end
			ST_EEPG: begin
				ea = {epg_r, cnt_r[EP_W-1:0]};
				ewe = em_r[cnt_r[EP_W-1:0]];
				ewd = eb_r[cnt_r[EP_W-1:0]];
				if (cnt_r == 32'(2**EP_W - 1)) begin
					em_nxt = '0;
					st_nxt = ST_WAIT;
					cnt_nxt = 32'(EE_WAIT);
				end else begin
					cnt_nxt = cnt_r + 32'd1;
				end
			end
			ST_ERASE: begin
				fwe = 1'b1;
				fa = cnt_r[FL_AW-1:0];
				fwd = {ERASED_BYTE, ERASED_BYTE};
				ewe = (cnt_r < 32'(2**EE_AW));
				ea = cnt_r[EE_AW-1:0];
				ewd = ERASED_BYTE;
				if (cnt_r == 32'(2**FL_AW - 1)) begin
					st_nxt = ST_WAIT;
					cnt_nxt = 32'(ERASE_WAIT);
				end else begin
					cnt_nxt = cnt_r + 32'd1;
				end
			end
			ST_WAIT: begin
				if (cnt_r == 32'd0) begin
					st_nxt = ST_IDLE;
				end else begin
					cnt_nxt = cnt_r - 32'd1;
				end
			end
			default: st_nxt = ST_IDLE;
		endcase
		// Instruction decode
		if (!in_mode) begin
			en_nxt = 1'b0;
		end else if (bus.rx_valid) begin
			tx_nxt = rd;
			case (bus.rx_idx)
				2'd0: b1_nxt = rd;
				2'd1: b2_nxt = rd;
				2'd2: begin
					b3_nxt = rd;
					if (en_r) begin
						case (b1_r)
							OP_POLL: tx_nxt = {7'h00, !idle};
							OP_RD_LOCK: tx_nxt = (b2_r == SUB_RD_HI) ? fh_r : lock_r;
							OP_RD_FUSE: tx_nxt = (b2_r == SUB_RD_HI) ? fe_r : fl_r;
							OP_RD_CAL: tx_nxt = CAL_VALUE;
							OP_RD_SIG: begin
								case (rd[1:0])
									2'd0: tx_nxt = SIG0;
									2'd1: tx_nxt = SIG1;
									2'd2: tx_nxt = SIG2;
									default: tx_nxt = ERASED_BYTE;
								endcase
							end
							OP_RD_FHI, OP_RD_FLO: begin
								if (idle) begin
									fa = ra[FL_AW-1:0];
									rs_nxt = (b1_r == OP_RD_FHI) ? RS_FHI : RS_FLO;
								end
							end
							OP_RD_EE: begin
								if (idle) begin
									ea = ra[EE_AW-1:0];
									rs_nxt = RS_EE;
								end
							end
							default: ;
						endcase
					end
				end
				default: begin
					if (b1_r == OP_ENABLE && b2_r == SUB_ENABLE) begin
						en_nxt = 1'b1;
					end else if (go) begin
						case (b1_r)
							OP_ENABLE: begin
								case (b2_r)
									SUB_ERASE: begin
										st_nxt = ST_ERASE;
										cnt_nxt = 32'd0;
										lock_nxt = LOCK_RST;
										em_nxt = '0;
										lov_nxt = 1'b0;
									end
									SUB_WR_LOCK: begin
										lock_nxt = lock_r & rd;
										st_nxt = ST_WAIT;
										cnt_nxt = 32'(FUSE_WAIT);
									end
									SUB_WR_FLO: begin
										fl_nxt = rd;
										st_nxt = ST_WAIT;
										cnt_nxt = 32'(FUSE_WAIT);
									end
									SUB_WR_FHI: begin
										fh_nxt = rd;
										st_nxt = ST_WAIT;
										cnt_nxt = 32'(FUSE_WAIT);
									end
									SUB_WR_FEXT: begin
										fe_nxt = rd;
										st_nxt = ST_WAIT;
										cnt_nxt = 32'(FUSE_WAIT);
									end
									default: ;
								endcase
							end
							OP_LD_EXT: ext_nxt = b3_r;
							OP_LD_FLO: begin
								bwe = 1'b1;
								ba = b3_r[PG_W-1:0];
								bwd = {ERASED_BYTE, rd};
								lo_nxt = rd;
								loa_nxt = b3_r[PG_W-1:0];
								lov_nxt = 1'b1;
							end
							OP_LD_FHI: begin
								bwe = 1'b1;
								ba = b3_r[PG_W-1:0];
								bwd = {rd, (lov_r && loa_r == b3_r[PG_W-1:0]) ? lo_r : ERASED_BYTE};
								lov_nxt = 1'b0;
							end
							OP_LD_EE: begin
								eb_nxt[b3_r[EP_W-1:0]] = rd;
								em_nxt[b3_r[EP_W-1:0]] = 1'b1;
							end
							OP_WR_FPAGE: begin
								pg_nxt = wa[FL_AW-1:PG_W];
								st_nxt = ST_FLASH;
								cnt_nxt = 32'd0;
							end
							OP_WR_EE: begin
								ewe = 1'b1;
								ea = wa[EE_AW-1:0];
								ewd = rd;
								st_nxt = ST_WAIT;
								cnt_nxt = 32'(EE_WAIT);
							end
							OP_WR_EEPG: begin
								epg_nxt = wa[EE_AW-1:EP_W];
								st_nxt = ST_EEPG;
								cnt_nxt = 32'd0;
							end
							default: ;
						endcase
					end
				end
			endcase
		end
		pend_nxt = (st_nxt != ST_IDLE);
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			b1_r <= 8'h00;
			b2_r <= 8'h00;
			b3_r <= 8'h00;
			ext_r <= 8'h00;
			lock_r <= LOCK_RST;
			fl_r <= FUSE_LO_RST;
			fh_r <= FUSE_HI_RST;
			fe_r <= FUSE_EXT_RST;
			tx_r <= 8'h00;
			lo_r <= 8'h00;
			loa_r <= '0;
			lov_r <= 1'b0;
			for (int i = 0; i < 2**EP_W; i++) begin
				eb_r[i] <= ERASED_BYTE;
			end
			em_r <= '0;
			epg_r <= '0;
			pg_r <= '0;
			cnt_r <= 32'd0;
			en_r <= 1'b0;
			pend_r <= 1'b0;
			st_r <= ST_IDLE;
			rs_r <= RS_NONE;
		end else begin
			b1_r <= b1_nxt;
			b2_r <= b2_nxt;
			b3_r <= b3_nxt;
			ext_r <= ext_nxt;
			lock_r <= lock_nxt;
			fl_r <= fl_nxt;
			fh_r <= fh_nxt;
			fe_r <= fe_nxt;
			tx_r <= tx_nxt;
			lo_r <= lo_nxt;
			loa_r <= loa_nxt;
			lov_r <= lov_nxt;
			eb_r <= eb_nxt;
			em_r <= em_nxt;
			epg_r <= epg_nxt;
			pg_r <= pg_nxt;
			cnt_r <= cnt_nxt;
			en_r <= en_nxt;
			pend_r <= pend_nxt;
			st_r <= st_nxt;
			rs_r <= rs_nxt;
		end
	end

	assign bus.tx_byte = tx_r;
	assign prog_enabled = en_r;
	assign op_pending = pend_r;
endmodule

// ### rtl/isp_pkg.sv
// Constants and types of the serial programming engine
// Assumes a 100 MHz system clock and one flash word of 16 bits
package isp_pkg;
	// Clock
	localparam int CLK_PERIOD_NS = 10;
	// Minimum wait delays, as printed, then in cycles
	localparam real FLASH_PAGE_WAIT_TIME_MS = 2.6;
	localparam real EEPROM_WRITE_WAIT_TIME_MS = 3.6;
	localparam real CHIP_ERASE_WAIT_TIME_MS = 10.5;
	localparam real FUSE_WRITE_WAIT_TIME_MS = 4.5;
	localparam int unsigned FLASH_PAGE_WAIT_CYC =
		int'($ceil(FLASH_PAGE_WAIT_TIME_MS * 1.0e6 / real'(CLK_PERIOD_NS) - 1.0e-6));
	localparam int unsigned EEPROM_WRITE_WAIT_CYC =
		int'($ceil(EEPROM_WRITE_WAIT_TIME_MS * 1.0e6 / real'(CLK_PERIOD_NS) - 1.0e-6));
	localparam int unsigned CHIP_ERASE_WAIT_CYC =
		int'($ceil(CHIP_ERASE_WAIT_TIME_MS * 1.0e6 / real'(CLK_PERIOD_NS) - 1.0e-6));
	localparam int unsigned FUSE_WRITE_WAIT_CYC =
		int'($ceil(FUSE_WRITE_WAIT_TIME_MS * 1.0e6 / real'(CLK_PERIOD_NS) - 1.0e-6));
	// Memory geometry
	localparam int FLASH_ADDR_W = 13;
	localparam int FLASH_PAGE_W = 6;
	localparam int EE_ADDR_W = 9;
	localparam int EE_PAGE_W = 2;
	// Instruction codes, first byte
	localparam logic [7:0] OP_ENABLE = 8'hAC;
	localparam logic [7:0] OP_POLL = 8'hF0;
	localparam logic [7:0] OP_LD_EXT = 8'h4D;
	localparam logic [7:0] OP_LD_FHI = 8'h48;
	localparam logic [7:0] OP_LD_FLO = 8'h40;
	localparam logic [7:0] OP_LD_EE = 8'hC1;
	localparam logic [7:0] OP_RD_FHI = 8'h28;
	localparam logic [7:0] OP_RD_FLO = 8'h20;
	localparam logic [7:0] OP_RD_EE = 8'hA0;
	localparam logic [7:0] OP_RD_LOCK = 8'h58;
	localparam logic [7:0] OP_RD_FUSE = 8'h50;
	localparam logic [7:0] OP_RD_SIG = 8'h30;
	localparam logic [7:0] OP_RD_CAL = 8'h38;
	localparam logic [7:0] OP_WR_FPAGE = 8'h4C;
	localparam logic [7:0] OP_WR_EE = 8'hC0;
	localparam logic [7:0] OP_WR_EEPG = 8'hC2;
	// Second byte after OP_ENABLE or a configuration read
	localparam logic [7:0] SUB_ENABLE = 8'h53;
	localparam logic [7:0] SUB_ERASE = 8'h80;
	localparam logic [7:0] SUB_WR_LOCK = 8'hE0;
	localparam logic [7:0] SUB_WR_FLO = 8'hA0;
	localparam logic [7:0] SUB_WR_FHI = 8'hA8;
	localparam logic [7:0] SUB_WR_FEXT = 8'hA4;
	localparam logic [7:0] SUB_RD_HI = 8'h08;
	// Values after reset and erase
	localparam logic [7:0] LOCK_RST = 8'hFF;
	localparam logic [7:0] FUSE_LO_RST = 8'hFF;
	localparam logic [7:0] FUSE_HI_RST = 8'hFF;
	localparam logic [7:0] FUSE_EXT_RST = 8'hFF;
	localparam logic [7:0] CAL_VALUE = 8'h80;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	// States
	typedef enum logic [2:0] {ST_IDLE, ST_FLASH, ST_EEPG, ST_ERASE, ST_WAIT} isp_state_e;
	typedef enum logic [1:0] {RS_NONE, RS_FHI, RS_FLO, RS_EE} isp_rsel_e;
endpackage

// ### rtl/isp_byte_if.sv
// Byte channel between the serial shifter and the instruction core
// Assumes both ends run on clk_sys
`timescale 1ns/100ps
interface isp_byte_if;
	logic active;
	logic rx_valid;
	logic [7:0] rx_byte;
	logic [1:0] rx_idx;
	logic [7:0] tx_byte;
	modport link (input active, input tx_byte, output rx_valid, output rx_byte, output rx_idx);
	modport core (output active, output tx_byte, input rx_valid, input rx_byte, input rx_idx);
endinterface

// ### rtl/isp_mem.sv
// Single-port memory with registered read data
// Assumes one access per cycle; contents are not reset
`timescale 1ns/100ps
module isp_mem #(
	parameter int W = 8,
	parameter int AW = 6
) (
	// Clock
	input wire logic clk_sys,
	// Access
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [W-1:0] wdata,
	output logic [W-1:0] rdata
);
	logic [W-1:0] mem [2**AW];

	always_ff @(posedge clk_sys) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule

// ### rtl/isp_link.sv
// Serial shifter: samples the programming pins and moves whole bytes
// Assumes sck phases of at least three clk_sys cycles
`timescale 1ns/100ps
module isp_link import isp_pkg::*; (
	// System
	input wire logic clk_sys,
	input wire logic reset_n,
	// Pins
	input wire logic sck,
	input wire logic mosi,
	output logic miso,
	// Byte channel
	isp_byte_if.link bus
);
	logic sck_s1_r, sck_s2_r, sck_s3_r, mosi_s1_r, mosi_s2_r;
	logic rise, fall;
	logic [2:0] bit_r, bit_nxt;
	logic [1:0] idx_r, idx_nxt, ridx_r, ridx_nxt;
	logic [7:0] sh_r, sh_nxt, tx_r, tx_nxt, rb_r, rb_nxt;
	logic rv_r, rv_nxt, miso_r, miso_nxt;

	always_comb begin
		rise = sck_s2_r && !sck_s3_r;
		fall = !sck_s2_r && sck_s3_r;
		bit_nxt = bit_r;
		idx_nxt = idx_r;
		ridx_nxt = ridx_r;
		sh_nxt = sh_r;
		tx_nxt = tx_r;
		rb_nxt = rb_r;
		rv_nxt = 1'b0;
		miso_nxt = miso_r;
		if (!bus.active) begin
			bit_nxt = 3'd0;
			idx_nxt = 2'd0;
			miso_nxt = 1'b0;
		end else if (rise) begin
			sh_nxt = {sh_r[6:0], mosi_s2_r};
			bit_nxt = bit_r + 3'd1;
			if (bit_r == 3'd7) begin
				rv_nxt = 1'b1;
				rb_nxt = {sh_r[6:0], mosi_s2_r};
				ridx_nxt = idx_r;
				idx_nxt = idx_r + 2'd1;
			end
		end else if (fall) begin
			if (bit_r == 3'd0) begin
				miso_nxt = bus.tx_byte[7];
				tx_nxt = {bus.tx_byte[6:0], 1'b0};
			end else begin
				miso_nxt = tx_r[7];
				tx_nxt = {tx_r[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			{sck_s1_r, sck_s2_r, sck_s3_r, mosi_s1_r, mosi_s2_r} <= 5'h00;
			bit_r <= 3'd0;
			idx_r <= 2'd0;
			ridx_r <= 2'd0;
			sh_r <= 8'h00;
			tx_r <= 8'h00;
			rb_r <= 8'h00;
			rv_r <= 1'b0;
			miso_r <= 1'b0;
		end else begin
			sck_s1_r <= sck;
			sck_s2_r <= sck_s1_r;
			sck_s3_r <= sck_s2_r;
			mosi_s1_r <= mosi;
			mosi_s2_r <= mosi_s1_r;
			bit_r <= bit_nxt;
			idx_r <= idx_nxt;
			ridx_r <= ridx_nxt;
			sh_r <= sh_nxt;
			tx_r <= tx_nxt;
			rb_r <= rb_nxt;
			rv_r <= rv_nxt;
			miso_r <= miso_nxt;
		end
	end

	assign miso = miso_r;
	assign bus.rx_valid = rv_r;
	assign bus.rx_byte = rb_r;
	assign bus.rx_idx = ridx_r;
endmodule

// ### verification/isp_engine_asserts.sv
// Port checker of the serial programming engine
// Assumes binding to isp_engine with its own count parameters
`timescale 1ns/100ps
module isp_engine_asserts import isp_pkg::*; #(
	parameter int FL_AW = FLASH_ADDR_W,
	parameter int unsigned FLASH_WAIT = FLASH_PAGE_WAIT_CYC,
	parameter int unsigned EE_WAIT = EEPROM_WRITE_WAIT_CYC,
	parameter int unsigned ERASE_WAIT = CHIP_ERASE_WAIT_CYC,
	parameter int unsigned FUSE_WAIT = FUSE_WRITE_WAIT_CYC
) (
	// System
	input wire logic clk_sys,
	input wire logic reset_n,
	// Pins
	input wire logic rst_pin_n,
	input wire logic sck,
	input wire logic mosi,
	input wire logic miso,
	// Status
	input wire logic prog_enabled,
	input wire logic op_pending
);
	localparam longint MIN_A = (FLASH_WAIT < EE_WAIT) ? FLASH_WAIT : EE_WAIT;
	localparam longint MIN_B = (ERASE_WAIT < FUSE_WAIT) ? ERASE_WAIT : FUSE_WAIT;
	localparam longint MIN_WAIT = (MIN_A < MIN_B) ? MIN_A : MIN_B;
	localparam longint MAX_PEND = (1 << FL_AW) + 80 + FLASH_WAIT + EE_WAIT + ERASE_WAIT
		+ FUSE_WAIT;
	logic sck_r, sck_nxt;
	logic [3:0] rise_r, rise_nxt, fall_r, fall_nxt, low_r, low_nxt;
	logic [31:0] pend_r, pend_nxt;
	// Cycles since serial clock edges, mode entry and pending start
	always_comb begin
		sck_nxt = sck;
		rise_nxt = (sck && !sck_r) ? 4'h0 : ((rise_r == 4'hF) ? 4'hF : rise_r + 4'h1);
		fall_nxt = (!sck && sck_r) ? 4'h0 : ((fall_r == 4'hF) ? 4'hF : fall_r + 4'h1);
		low_nxt = rst_pin_n ? 4'h0 : ((low_r == 4'hF) ? 4'hF : low_r + 4'h1);
		pend_nxt = op_pending ? pend_r + 32'h1 : 32'h0;
	end
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			sck_r <= 1'b0;
			rise_r <= 4'hF;
			fall_r <= 4'hF;
			low_r <= 4'h0;
			pend_r <= 32'h0;
		end else begin
			sck_r <= sck_nxt;
			rise_r <= rise_nxt;
			fall_r <= fall_nxt;
			low_r <= low_nxt;
			pend_r <= pend_nxt;
		end
	end
	a_miso_after_fall: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$changed(miso) && low_r > 4'h5 |-> fall_r <= 4'h6)
		else $error("miso moved away from a serial clock fall");
	a_mode_exit: assert property (@(posedge clk_sys) disable iff (!reset_n)
		rst_pin_n [*4] |=> !prog_enabled && !miso)
		else $error("mode kept with reset pin high");
	a_enable_in_mode: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$rose(prog_enabled) |-> $past(rst_pin_n, 4) == 1'b0)
		else $error("enabled outside programming mode");
	a_enable_on_frame: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$rose(prog_enabled) |-> rise_r <= 4'h6)
		else $error("enable not at a frame end");
	a_pending_on_frame: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$rose(op_pending) |-> rise_r <= 4'h6)
		else $error("operation started off a frame end");
	a_pending_needs_enable: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$rose(op_pending) |-> prog_enabled)
		else $error("operation started while not enabled");
	a_pending_min_wait: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$fell(op_pending) |-> pend_r > MIN_WAIT)
		else $error("pending flag cleared too early");
	a_pending_bounded: assert property (@(posedge clk_sys) disable iff (!reset_n)
		op_pending |-> pend_r <= MAX_PEND)
		else $error("pending flag never clears");
endmodule
bind isp_engine isp_engine_asserts #(.FL_AW(FL_AW), .FLASH_WAIT(FLASH_WAIT), .EE_WAIT(EE_WAIT),
	.ERASE_WAIT(ERASE_WAIT), .FUSE_WAIT(FUSE_WAIT)) chk (.clk_sys(clk_sys), .reset_n(reset_n),
	.rst_pin_n(rst_pin_n), .sck(sck), .mosi(mosi), .miso(miso), .prog_enabled(prog_enabled),
	.op_pending(op_pending));

// ### verification/isp_prog_model.sv
// Model of the external programmer driving the serial pins
// Assumes phases of HALF_NS, well above three system clock cycles
`timescale 1ns/100ps
module isp_prog_model #(
	parameter int HALF_NS = 60
) (
	// Programming pins
	output logic rst_pin_n,
	output logic sck,
	input wire logic miso,
	output logic mosi
);
	initial begin
		rst_pin_n = 1'b0;
		sck = 1'b0;
		mosi = 1'b0;
	end
	// Positive reset pulse, then a fixed 200 ns settle wait
	task automatic pulse();
		rst_pin_n = 1'b1;
		#60;
		rst_pin_n = 1'b0;
		#200;
	endtask
	// Always four whole bytes, MSB first
	task automatic xfer(input logic [31:0] cmd, output logic [31:0] resp);
		#3;
		for (int i = 31; i >= 0; i--) begin
			mosi = cmd[i];
			#(HALF_NS);
			sck = 1'b1;
			resp[i] = miso;
			#(HALF_NS);
			sck = 1'b0;
		end
		mosi = ~mosi;
	endtask
endmodule

// ### verification/isp_engine_tb.sv
// Testbench of the serial programming engine
// Assumes the programmer model paces the serial pins
`timescale 1ns/100ps
module isp_engine_tb import isp_pkg::*;;
	localparam int unsigned WAIT_CYC = 2000;
	localparam logic [7:0] SIG_A = 8'h3C; // Arbitrary value
	localparam logic [7:0] SIG_B = 8'hC3; // Arbitrary value
	localparam logic [7:0] SIG_C = 8'h96; // Arbitrary value
	logic clk_sys = 1'b0;
	logic reset_n;
	logic rst_pin_n, sck, mosi, miso, prog_enabled, op_pending;
	logic [31:0] resp;
	int err_count = 0;
	int checked = 0;
	always #5 clk_sys = ~clk_sys;
	isp_engine #(.FL_AW(8), .EE_AW(8), .FLASH_WAIT(WAIT_CYC), .EE_WAIT(WAIT_CYC),
		.ERASE_WAIT(WAIT_CYC), .FUSE_WAIT(WAIT_CYC), .SIG0(SIG_A), .SIG1(SIG_B), .SIG2(SIG_C))
		uut (.clk_sys(clk_sys),
		.reset_n(reset_n), .rst_pin_n(rst_pin_n), .sck(sck), .mosi(mosi), .miso(miso),
		.prog_enabled(prog_enabled), .op_pending(op_pending));
	isp_prog_model #(.HALF_NS(60)) prog (.rst_pin_n(rst_pin_n), .sck(sck), .miso(miso),
		.mosi(mosi));
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic cmd(input logic [31:0] c);
		prog.xfer(c, resp);
	endtask
	task automatic rd(input logic [23:0] c, input logic [7:0] exp, input string what);
		prog.xfer({c, 8'h00}, resp);
		check(what, resp[7:0], exp);
	endtask
	// Poll until the pending flag reads zero
	task automatic idle();
		int n;
		n = 0;
		prog.xfer(32'hF000_0000, resp);
		while (resp[0] !== 1'b0 && n < 20) begin
			prog.xfer(32'hF000_0000, resp);
			n++;
		end
		check("poll", resp[7:0], 8'h00);
	endtask
	task automatic t_enable();
		prog.pulse();
		prog.xfer(32'hAC53_0000, resp);
		check("echo", resp[15:8], 8'h53);
		check("enabled", {7'h00, prog_enabled}, 8'h01);
		$display("test enable done");
	endtask
	task automatic t_erase();
		cmd(32'hAC80_0000);
		prog.xfer(32'hF000_0000, resp);
		check("busy", resp[7:0], 8'h01);
		idle();
		rd(24'h200010, 8'hFF, "flash");
		rd(24'hA00007, 8'hFF, "eeprom");
		$display("test erase done");
	endtask
	task automatic t_gate();
		prog.pulse();
		check("left mode", {7'h00, prog_enabled}, 8'h00);
		cmd(32'hC000_053C);
		check("ignored", {7'h00, op_pending}, 8'h00);
		cmd(32'hAC53_0000);
		rd(24'hA00005, 8'hFF, "eeprom");
		$display("test gate done");
	endtask
	task automatic t_eeprom();
		cmd(32'hC000_053C);
		prog.xfer(32'hF000_0000, resp);
		check("busy", resp[7:0], 8'h01);
		idle();
		rd(24'hA00005, 8'h3C, "eeprom byte");
		cmd(32'hC100_0255);
		cmd(32'hC200_0400);
		idle();
		rd(24'hA00006, 8'h55, "page byte");
		rd(24'hA00005, 8'h3C, "kept byte");
		rd(24'hA00004, 8'hFF, "kept erased");
		$display("test eeprom done");
	endtask
	task automatic t_flash();
		cmd(32'h4D00_0000);
		cmd(32'h4000_0334);
		cmd(32'h4800_0312);
		cmd(32'h4C00_5F00);
		idle();
		rd(24'h200043, 8'h34, "flash low");
		rd(24'h280043, 8'h12, "flash high");
		rd(24'h200003, 8'hFF, "other page");
		$display("test flash done");
	endtask
	task automatic t_config();
		logic [7:0] wsub [4] = '{8'hA0, 8'hA8, 8'hA4, 8'hE0};
		logic [23:0] rop [4] = '{24'h500000, 24'h580800, 24'h500800, 24'h580000};
		logic [7:0] val [4] = '{8'h62, 8'hD9, 8'hF9, 8'hFC};
		for (int i = 0; i < 4; i++) begin
			cmd({8'hAC, wsub[i], 8'h00, val[i]});
			idle();
			rd(rop[i], val[i], "config");
		end
		rd(24'h300000, SIG_A, "signature");
		rd(24'h300001, SIG_B, "signature 1");
		rd(24'h300002, SIG_C, "signature 2");
		rd(24'h300003, ERASED_BYTE, "signature 3");
		rd(24'h380000, CAL_VALUE, "calibration");
		$display("test config done");
	endtask
	initial begin
		reset_n <= 1'b0;
		repeat (5) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		t_enable();
		t_erase();
		t_gate();
		t_eeprom();
		t_flash();
		t_config();
		summarize();
	end
	initial begin
		repeat (90000) @(posedge clk_sys);
		err_count++;
		summarize();
	end
endmodule
